// file: src/eeprom_read_path.sv
`timescale 1ns/1ns
// Contract
// - reads ignore the write-protect input entirely.
// - repeated start then read select; device acks and sends the byte.
// - start plus read select returns byte at current counter.
// - address counter advances by one after each returned byte.
// - master ack after a byte makes device send the byte at the next address.
// - counter wraps from top location back to zero.
// - device releases data and samples master ack in ninth period.
// - high in ack slot ends reading, device goes idle.
// - select byte is four-bit type then three-bit chip-enable, msb first.
// - respond only when chip-enable field matches pins, else idle.
// - eighth select bit is one for read, zero for write.
// - receiver pulls data low in ninth period to acknowledge.
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sync_fifo

module eeprom_read_path
  import eeprom_rd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  input wire logic write_protect_input,
  // memory data stream into the fifo
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic mem_valid,
  output logic mem_ready,
  output logic [ADDR_W-1:0] mem_addr,
  // shared with the write path
  output logic [ADDR_W-1:0] addr_cnt,
  output logic busy
);
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [2:0] ce_m, ce_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  st_t st_r;
  logic [BIT_CNT_W-1:0] bit_r;
  logic [DATA_W-1:0] sh_r;
  logic [ADDR_W-1:0] addr_r, fetch_r;
  logic drive_low_r, oe_r;
  logic [DATA_W-1:0] fifo_dout;
  logic fifo_valid, fifo_pop, fifo_in_ready;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      ce_m <= 3'h0;
      ce_s <= 3'h0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      ce_m <= {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
      ce_s <= ce_m;
    end
  end
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;

  // fifo fills from mem_data and pops on each master ack, but fifo_dout is unused; the engine loads mem_data directly
  assign fifo_pop = (st_r == ST_TX_ACK) && scl_fall && bit_r == ACK_SLOT
    && !sda_d && oe_r == 1'b0;
  sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst(rst),
    .in_data(mem_data),
    .in_valid(mem_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_dout),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // simple single-byte fetch: mem_addr follows the counter every cycle, mem_ready follows fifo room
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_ready <= 1'b0;
      mem_addr <= ADDR_RST;
    end else begin
      mem_addr <= addr_r;
      mem_ready <= fifo_in_ready;
    end
  end

  // serial engine; write_protect_input deliberately unread
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bit_r <= BIT_ZERO;
      sh_r <= 8'h00;
      addr_r <= ADDR_RST;
      fetch_r <= ADDR_RST;
      drive_low_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
      drive_low_r <= 1'b0;
    end else if (start_det) begin
      st_r <= ST_SEL; // repeated start also lands here
      bit_r <= BIT_ZERO;
      oe_r <= 1'b0;
      drive_low_r <= 1'b0;
    end else if (scl_rise) begin
      case (st_r)
        ST_SEL, ST_ADDR, ST_WRDATA: begin
          sh_r <= {sh_r[DATA_W-2:0], sda_s};
          bit_r <= bit_r + 4'h1;
        end
        ST_TX_ACK: begin
          if (sda_s) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        ST_SEL: begin
          if (bit_r == ACK_SLOT) begin
            if (sh_r[7:4] == DEV_TYPE_ID && sh_r[3:1] == ce_s) begin
              st_r <= ST_SEL_ACK;
              oe_r <= 1'b1;
              drive_low_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_SEL_ACK: begin
          bit_r <= BIT_ZERO;
          if (sh_r[0]) begin
            st_r <= ST_TX;
            sh_r <= mem_data;
            fetch_r <= addr_r;
            oe_r <= 1'b1;
            drive_low_r <= !mem_data[7];
          end else begin
            st_r <= ST_ADDR;
            oe_r <= 1'b0;
            drive_low_r <= 1'b0;
          end
        end
        ST_ADDR: begin
          if (bit_r == ACK_SLOT) begin
            addr_r <= {3'h0, sh_r};
            st_r <= ST_ADDR_ACK;
            oe_r <= 1'b1;
            drive_low_r <= 1'b1;
          end
        end
        ST_ADDR_ACK: begin
          st_r <= ST_WRDATA;
          bit_r <= BIT_ZERO;
          oe_r <= 1'b0;
          drive_low_r <= 1'b0;
        end
        ST_TX: begin
          if (bit_r == LAST_DBIT) begin
            oe_r <= 1'b0;
            drive_low_r <= 1'b0;
            st_r <= ST_TX_ACK;
            bit_r <= ACK_SLOT;
            addr_r <= (addr_r == ADDR_TOP) ? ADDR_RST : addr_r + 11'h001;
          end else begin
            bit_r <= bit_r + 4'h1;
            sh_r <= {sh_r[DATA_W-2:0], 1'b0};
            drive_low_r <= !sh_r[6];
          end
        end
        ST_TX_ACK: begin
          st_r <= ST_TX;
          bit_r <= BIT_ZERO;
          sh_r <= mem_data;
          fetch_r <= addr_r;
          oe_r <= 1'b1;
          drive_low_r <= !mem_data[7];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      addr_cnt <= ADDR_RST;
      busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= oe_r && drive_low_r;
      addr_cnt <= addr_r;
      busy <= st_r != ST_IDLE;
    end
  end

  AST_NACK_IDLE: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_TX_ACK && scl_rise && sda_s && !stop_det && !start_det
    |=> st_r == ST_IDLE)
    else $error("nack did not end read");
  AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_TX && scl_fall && bit_r == LAST_DBIT && addr_r == ADDR_TOP
    && !stop_det && !start_det |=> addr_r == ADDR_RST)
    else $error("counter did not wrap");
  AST_INC: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_TX && scl_fall && bit_r == LAST_DBIT && addr_r != ADDR_TOP
    && !stop_det && !start_det |=> addr_r == $past(addr_r) + 11'h001)
    else $error("counter did not advance");
  AST_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_TX_ACK |-> !oe_r)
    else $error("data held in ack slot");
  AST_CHANGE_LOW: assert property (@(posedge mclk) disable iff (rst)
    $changed(drive_low_r) && st_r == ST_TX |-> !scl_s)
    else $error("data changed while clock high");
  AST_MISMATCH: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_SEL && scl_fall && bit_r == ACK_SLOT && sh_r[3:1] != ce_s
    && !stop_det && !start_det |=> st_r == ST_IDLE)
    else $error("wrong chip answered");
  AST_SEL_ACK: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_SEL_ACK |-> oe_r && drive_low_r)
    else $error("select not acked");
  AST_READ_DIR: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_SEL_ACK && scl_fall && sh_r[0] && !stop_det && !start_det
    |=> st_r == ST_TX)
    else $error("read select did not send");
  COV_SEQ: cover property (@(posedge mclk) st_r == ST_TX_ACK && scl_fall
    && !stop_det && !start_det);
  COV_RANDOM: cover property (@(posedge mclk) st_r == ST_ADDR_ACK);
  COV_NACK: cover property (@(posedge mclk) st_r == ST_TX_ACK && scl_rise
    && sda_s);
endmodule // eeprom_read_path

// file: src/eeprom_rd_pkg.sv
package eeprom_rd_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_CNT_W = 4;
  // value is arbitrary, not a real maker code
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 11'h7ff;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [BIT_CNT_W-1:0] ACK_SLOT = 4'h8;
  localparam logic [BIT_CNT_W-1:0] LAST_DBIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_SEL_ACK, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_TX_ACK,
    ST_WRDATA
  } st_t;
endpackage

// file: tb/i2c_master_model.sv
`timescale 1ns/1ns
// open-drain master; scl parks high between frames
module i2c_master_model #(
  parameter int HALF = 12
) (
  // clock
  input wire logic mclk,
  // bus
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // sda moves well after scl falls, else a false start or stop
  task automatic put_bit(input logic b);
    tick(4);
    sda_low = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    tick(4);
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    b = sda_line;
    scl = 1'b0;
  endtask
  // doubles as repeated start when scl is low
  task automatic start;
    tick(4);
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic stop;
    tick(4);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~ack);
  endtask
endmodule // i2c_master_model

// file: tb/tb_eeprom_read_path.sv
`timescale 1ns/1ns
module tb_eeprom_read_path
  import eeprom_rd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cs = 3'h5;
  logic wp = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, mem_ready, busy;
  logic [ADDR_W-1:0] mem_addr, addr_cnt, exp_addr;
  logic [DATA_W-1:0] mem_data;
  // pull-up on the data line
  wire logic sda_line = ~(sda_low | sda_oe);
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  // contents vary with every address bit
  function automatic logic [7:0] mem_of(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h3c;
  endfunction
  assign mem_data = mem_of(mem_addr);
  eeprom_read_path i_dut (.mclk(mclk), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_sel_bit0(cs[0]), .chip_sel_bit1(cs[1]), .chip_sel_bit2(cs[2]),
    .write_protect_input(wp), .mem_data(mem_data), .mem_valid(1'b1),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .addr_cnt(addr_cnt),
    .busy(busy));
  i2c_master_model i_master (.mclk(mclk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));
  task automatic check(input logic [15:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] sel(input logic [2:0] c, input logic rd);
    return {DEV_TYPE_ID, c, rd};
  endfunction
  task automatic load_addr(input logic [7:0] a);
    logic ack;
    i_master.start();
    i_master.wr_byte(sel(cs, 1'b0), ack);
    check(ack, 1'b1, "wr sel ack");
    i_master.wr_byte(a, ack);
    check(ack, 1'b1, "addr ack");
    i_master.start();
    i_master.wr_byte(sel(cs, 1'b1), ack);
    check(ack, 1'b1, "rd sel ack");
    exp_addr = {3'h0, a};
  endtask
  // acks all but the last byte
  task automatic read_run(input int n);
    logic [7:0] d;
    for (int i = 1; i <= n; i++) begin
      i_master.rd_byte(i < n, d);
      check(d, mem_of(exp_addr), "data");
      exp_addr = exp_addr + 1'b1;
    end
    i_master.stop();
    i_master.tick(8);
    check(busy, 1'b0, "idle");
    check(addr_cnt, exp_addr, "counter");
    check(mem_addr, exp_addr, "fetch addr");
    check(sda_out, 1'b0, "open drain level");
  endtask
  task automatic t_random(input logic [7:0] a, input logic p);
    wp = p;
    load_addr(a);
    read_run(1);
    $display("random read %h wp %b done", a, p);
  endtask
  task automatic t_current;
    logic ack;
    i_master.start();
    i_master.wr_byte(sel(cs, 1'b1), ack);
    check(ack, 1'b1, "cur sel ack");
    read_run(1);
    $display("current read done");
  endtask
  task automatic t_seq;
    load_addr(8'hfe);
    read_run(4); // crosses into the upper counter bits
    t_current();
    $display("sequential read done");
  endtask
  task automatic t_reject;
    logic ack;
    i_master.start();
    i_master.wr_byte(sel(cs ^ 3'h1, 1'b1), ack);
    check(ack, 1'b0, "foreign chip");
    i_master.stop();
    i_master.start();
    i_master.wr_byte({DEV_TYPE_ID ^ 4'h1, cs, 1'b1}, ack);
    check(ack, 1'b0, "foreign type");
    i_master.stop();
    i_master.tick(8);
    check(busy, 1'b0, "idle");
    check(addr_cnt, exp_addr, "counter kept");
    $display("reject done");
  endtask
  // whole run needs under 12000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    exp_addr = '0;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    i_master.tick(4);
    t_current();
    t_random(8'h2a, 1'b0);
    t_random(8'h80, 1'b1);
    t_seq();
    t_reject();
    cs = 3'h2;
    t_current();
    print_verdict();
  end
endmodule // tb_eeprom_read_path
